// ==== bench/dcfm_vfc_model.sv ====
`default_nettype none
// ------------------------------------------------------------
// converter and input multiplexer model
// ------------------------------------------------------------
module dcfm_vfc_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [4:0] mux_sel,
	output logic            vfc_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned cyc;  // clocks since reset release
	int unsigned half; // half period in clocks
	assign half = (mux_sel == 5'h10) ? 8 : 5;
	// square wave locked to the frame grid, so a window holds whole cycles
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cyc    <= 0;
			vfc_in <= 1'h0;
		end else begin
			cyc    <= cyc + 1;
			vfc_in <= (cyc % (2 * half)) >= half;
		end
	end
endmodule : dcfm_vfc_model
`default_nettype wire

// ==== bench/tb_dual_counter_frequency_meter.sv ====
`default_nettype none
`include "dcfm_map.svh"
module tb_dual_counter_frequency_meter
	import dcfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int FRAME_LEN = 400; // clocks per minor frame
	logic        clk;
	logic        resetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        vfc_in;
	logic        minor_frame;
	logic        major_frame;
	logic [4:0]  mux_sel;
	logic        cond_polarity;
	logic        cond_narrow;
	logic        result_strobe;
	int          fails;
	int          check_count;
	int          fcyc;     // position in frame
	int          frame_no; // frames sent
	logic [31:0] cw [4]  = '{32'h316, 32'h16, 32'h17, 32'h115}; // control words
	logic        nar [4] = '{1'h1, 1'h1, 1'h1, 1'h0};           // narrow expected
	logic [1:0]  md [2]  = '{DCFM_NATIVE, 2'h3};                 // both native
	logic [4:0]  src [2] = '{5'h11, 5'h10};                      // reference, ground
	int          per [2] = '{10, 16};                            // converter period
	dcfm_top i_dcfm_top (
		.clk           (clk),
		.resetn        (resetn),
		.paddr         (paddr),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.vfc_in        (vfc_in),
		.minor_frame   (minor_frame),
		.major_frame   (major_frame),
		.mux_sel       (mux_sel),
		.cond_polarity (cond_polarity),
		.cond_narrow   (cond_narrow),
		.result_strobe (result_strobe)
	);
	dcfm_vfc_model i_dcfm_vfc_model (
		.clk     (clk),
		.resetn  (resetn),
		.mux_sel (mux_sel),
		.vfc_in  (vfc_in)
	);
	// ------------------------------------------------------------
	// clock and frame grid
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// minor frame pulse every FRAME_LEN clocks, major on every fourth
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fcyc        <= 0;
			frame_no    <= 0;
			minor_frame <= 1'h0;
			major_frame <= 1'h0;
		end else begin
			fcyc        <= (fcyc == FRAME_LEN - 1) ? 0 : fcyc + 1;
			minor_frame <= (fcyc == FRAME_LEN - 1);
			major_frame <= (fcyc == FRAME_LEN - 1) && (frame_no % 4 == 0);
			if (fcyc == FRAME_LEN - 1) begin
				frame_no <= frame_no + 1;
			end
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
		check_count++;
		if ($isunknown(got) || got < lo || got > hi) begin
			fails++;
			$display("Error %s expected %0d..%0d seen %0h", what, lo, hi, got);
		end
	endtask : chk_rng
	// one transfer; request held until pready is seen high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 100);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (n >= 100) begin
			fails++;
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(a, 1'h1, d, q, e);
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(a, 1'h0, 32'h0, q, e);
	endtask : rd
	// clocks until the next result pulse, bounded
	task automatic wait_strobe(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (result_strobe !== 1'h1 && n < 4000);
		// a missing result counts against the run
		if (n >= 4000) begin
			fails++;
			$display("Error result_strobe expected pulse seen none");
		end
	endtask : wait_strobe
	task automatic wait_major();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (major_frame !== 1'h1 && n < 2000);
		if (n >= 2000) begin
			fails++;
			$display("Error major_frame expected pulse seen none");
		end
		repeat (20) @(posedge clk);
	endtask : wait_major
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [31:0] e1;
		logic [31:0] t1;
		logic        er;
		int          n;
		fails = 0;
		check_count = 0;
		resetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		resetn <= 1'h1;
		@(negedge clk);
		chk_val("mux_sel", 32'h10, mux_sel);
		chk_val("cond_narrow", 32'h0, cond_narrow);
		chk_val("pready", 32'h1, pready);
		rd(`DCFM_OFF_CTRL, q);
		chk_val("ctrl", 32'h0, q);
		apb(12'h014, 1'h0, 32'h0, q, er);
		chk_val("pslverr", 32'h1, er);
		// firmware steps every defined source well inside one major frame
		for (int s = 0; s < 25; s++) begin
			wr(`DCFM_OFF_CWORD, s);
			chk_val("mux_sel", s, mux_sel);
		end
		// source, polarity and range table; first two are a reversed pair
		for (int i = 0; i < 4; i++) begin
			wr(`DCFM_OFF_CWORD, cw[i]);
			chk_val("mux_sel", cw[i][4:0], mux_sel);
			chk_val("cond_polarity", cw[i][8], cond_polarity);
			chk_val("cond_narrow", nar[i], cond_narrow);
		end
		// select 25 is beyond the source count and must leave the word alone
		wr(`DCFM_OFF_CWORD, 32'h19);
		chk_val("mux_sel", 32'h15, mux_sel);
		wr(`DCFM_OFF_CWORD, 32'h18);
		rd(`DCFM_OFF_CWORD, q);
		chk_val("cword", 32'h18, q);
		// windowed counting in native mode and in the spare code
		for (int i = 0; i < 2; i++) begin
			wr(`DCFM_OFF_CTRL, {30'h0, md[i]});
			wr(`DCFM_OFF_CWORD, {27'h0, src[i]});
			wait_strobe(n);
			wait_strobe(n);
			chk_val("strobe spacing", 4 * FRAME_LEN, n);
			@(negedge clk);
			chk_val("result_strobe", 32'h0, result_strobe);
			rd(`DCFM_OFF_EDGE, e1);
			chk_val("edge_count", 2 * FRAME_LEN / per[i], e1);
			rd(`DCFM_OFF_TBASE, t1);
			chk_rng("timebase_count", 38, 42, t1);
			// downstream rate: half the edges over the timebase ticks, scaled
			chk_rng("rate ratio", 9400 / per[i], 10600 / per[i], e1 / 2 * 1000 / t1);
			rd(`DCFM_OFF_STAT, q);
			chk_val("ready", 32'h1, q[0]);
			wr(`DCFM_OFF_STAT, 32'h1);
			rd(`DCFM_OFF_STAT, q);
			chk_val("ready", 32'h0, q[0]);
		end
		// timebase held off, converter still counted
		wr(`DCFM_OFF_CTRL, 32'h1);
		wait_strobe(n);
		wait_strobe(n);
		rd(`DCFM_OFF_EDGE, q);
		chk_val("edge_count", 2 * FRAME_LEN / 16, q);
		rd(`DCFM_OFF_TBASE, q);
		chk_val("timebase_count", 32'h0, q);
		// free running, latched at each major frame
		wr(`DCFM_OFF_CTRL, 32'h2);
		wait_major();
		rd(`DCFM_OFF_EDGE, e1);
		rd(`DCFM_OFF_TBASE, t1);
		wait_major();
		rd(`DCFM_OFF_EDGE, q);
		chk_val("edge step", 2 * 4 * FRAME_LEN / 16, {16'h0, q[15:0] - e1[15:0]});
		rd(`DCFM_OFF_TBASE, q);
		chk_rng("timebase step", 158, 162, {10'h0, q[21:0] - t1[21:0]});
		stop_test();
	end
	// hang guard, well beyond the roughly 12000 clocks the tests need
	initial begin
		#2000000;
		fails++;
		stop_test();
	end
endmodule : tb_dual_counter_frequency_meter
`default_nettype wire

// ==== verilog/dcfm_ctr_if.sv ====
`default_nettype none
`include "dcfm_map.svh"
interface dcfm_ctr_if;
	logic                     clr;        // aligned window start
	logic                     run;        // counters gated on
	logic                     tb_en;      // timebase allowed
	logic                     edge_evt;   // any converter edge
	logic [`DCFM_EDGE_W-1:0]  edge_count; // converter half cycles
	logic [`DCFM_TB_W-1:0]    tb_count;   // timebase ticks
	modport ctl_side  (output clr, run, tb_en, edge_evt, input edge_count, tb_count);
	modport edge_side (input clr, run, edge_evt, output edge_count);
	modport tb_side   (input clr, run, tb_en, output tb_count);
endinterface : dcfm_ctr_if
`default_nettype wire

// ==== verilog/dcfm_edge_ctr.sv ====
`default_nettype none
`include "dcfm_map.svh"
module dcfm_edge_ctr (
	input wire logic   clk,
	input wire logic   resetn,
	dcfm_ctr_if.edge_side cif
);
	logic [`DCFM_EDGE_W-1:0] cnt_reg;  // running count
	logic [`DCFM_EDGE_W-1:0] cnt_next; // next count
	// ------------------------------------------------------------
	// both-edge counting
	// ------------------------------------------------------------
	// rise and fall both count
	assign cnt_next = cif.clr ? '0 :
		(cif.run & cif.edge_evt) ? cnt_reg + 1'b1 : cnt_reg;
	assign cif.edge_count = cnt_reg;
	// count register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_edge_both_inc: assert property (@(posedge clk) disable iff (!resetn)
		cif.run && cif.edge_evt && !cif.clr |=> cif.edge_count == $past(cif.edge_count) + 1'b1)
		else $error("edge count missed a converter edge");
	a_edge_clear: assert property (@(posedge clk) disable iff (!resetn)
		cif.clr |=> cif.edge_count == '0)
		else $error("edge count not cleared at window start");
endmodule : dcfm_edge_ctr
`default_nettype wire

// ==== verilog/dcfm_map.svh ====
`ifndef DCFM_MAP_SVH
`define DCFM_MAP_SVH
// ------------------------------------------------------------
// timing constants
// ------------------------------------------------------------
`define DCFM_CLK_HZ    20000000
`define DCFM_TB_HZ     2000000
`define DCFM_TB_DIV    (`DCFM_CLK_HZ / `DCFM_TB_HZ)
`define DCFM_WIN_MS    161
`define DCFM_EDGE_W    16
`define DCFM_TB_W      22
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DCFM_OFF_CTRL  12'h000
`define DCFM_OFF_CWORD 12'h004
`define DCFM_OFF_EDGE  12'h008
`define DCFM_OFF_TBASE 12'h00C
`define DCFM_OFF_STAT  12'h010
// ------------------------------------------------------------
// field positions and source codes
// ------------------------------------------------------------
`define DCFM_CW_SEL_HI 4
`define DCFM_CW_POL    8
`define DCFM_CW_NARROW 9
`define DCFM_ST_READY  0
`define DCFM_SRC_MAX   5'h18
`define DCFM_SRC_GND   5'h10
`define DCFM_SRC_VREF  5'h11
`define DCFM_SRC_RTL_N 5'h16
`define DCFM_SRC_RTH_N 5'h17
`define DCFM_PHASE_RST 2'h0
`endif

// ==== verilog/dcfm_pkg.sv ====
`default_nettype none
package dcfm_pkg;
	// counter mode select
	typedef enum logic [1:0] {
		DCFM_NATIVE     = 2'h0,
		DCFM_TB_INHIBIT = 2'h1,
		DCFM_CONTINUOUS = 2'h2
	} dcfm_mode_e;
	// window sequencer, gray along the usual path
	typedef enum logic [1:0] {
		DCFM_IDLE  = 2'h0,
		DCFM_ARM   = 2'h1,
		DCFM_RUN   = 2'h3,
		DCFM_DRAIN = 2'h2
	} dcfm_state_e;
	// unused code 3 falls back to native behaviour
	function automatic dcfm_mode_e dcfm_mode_norm(input logic [1:0] m);
		dcfm_mode_norm = (m == 2'h3) ? DCFM_NATIVE : dcfm_mode_e'(m);
	endfunction : dcfm_mode_norm
endpackage : dcfm_pkg
`default_nettype wire

// ==== verilog/dcfm_tb_ctr.sv ====
`default_nettype none
`include "dcfm_map.svh"
module dcfm_tb_ctr (
	input wire logic clk,
	input wire logic resetn,
	dcfm_ctr_if.tb_side cif
);
	localparam int DIV = `DCFM_TB_DIV;
	localparam int DW  = $clog2(DIV);
	logic [DW-1:0]         div_reg;  // prescaler phase
	logic                  tick;     // one timebase period
	logic [`DCFM_TB_W-1:0] cnt_reg;  // timebase count
	// ------------------------------------------------------------
	// timebase prescaler
	// ------------------------------------------------------------
	// timebase divided from system clock
	assign tick = (div_reg == DW'(DIV - 1));
	// free-running divider, never gated so its rate is steady
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_reg <= '0;
		end else begin
			div_reg <= tick ? '0 : div_reg + 1'b1;
		end
	end
	// ------------------------------------------------------------
	// gated timebase counter
	// ------------------------------------------------------------
	// wide counter for long windows
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else if (cif.clr) begin
			cnt_reg <= '0;
		end else if (cif.run & cif.tb_en & tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	assign cif.tb_count = cnt_reg;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_tb_tick_rate: assert property (@(posedge clk) disable iff (!resetn)
		tick |=> !tick [*8] ##1 !tick ##1 tick)
		else $error("timebase tick spacing wrong");
	a_tb_inhibit: assert property (@(posedge clk) disable iff (!resetn)
		!cif.tb_en && !cif.clr |=> $stable(cif.tb_count))
		else $error("timebase counted while inhibited");
endmodule : dcfm_tb_ctr
`default_nettype wire

// ==== verilog/dcfm_top.sv ====
`default_nettype none
`include "dcfm_map.svh"
module dcfm_top
	import dcfm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vfc_in,
	input  wire logic        minor_frame,
	input  wire logic        major_frame,
	output logic      [4:0]  mux_sel,
	output logic             cond_polarity,
	output logic             cond_narrow,
	output logic             result_strobe
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int EW = `DCFM_EDGE_W;
	localparam int TW = `DCFM_TB_W;
	localparam int WIN_MS = `DCFM_WIN_MS; // nominal frame, set by strobes
	dcfm_ctr_if ctr ();                   // counter control bundle
	logic [1:0]    mode_reg;              // counter mode
	logic [4:0]    sel_reg;               // source select
	logic          pol_reg;               // polarity reverse
	logic          narrow_reg;            // restricted range
	logic [1:0]    phase_reg;             // minor frame in cycle
	logic [1:0]    phase_next;
	dcfm_state_e   state_reg;             // window sequencer
	dcfm_state_e   state_next;
	logic          vfc_reg;               // last converter level
	logic          win_id_reg;            // second window of cycle
	logic [EW-1:0] edge_hold_reg;         // held edge count
	logic [TW-1:0] tb_hold_reg;           // held timebase count
	logic          ready_reg;             // new result sticky
	logic          strobe_reg;            // new result pulse
	dcfm_mode_e    mode_eff;
	logic          cont_mode;
	logic          vfc_rise;
	logic          vfc_edge;
	logic          start_flag;
	logic          end_flag;
	logic          arm_hit;
	logic          stop_hit;
	logic          latch_native;
	logic          latch_cont;
	logic          latch;
	logic          wr_en;
	logic          hit_ctrl;
	logic          hit_cword;
	logic          hit_edge;
	logic          hit_tbase;
	logic          hit_stat;
	logic          mapped;
	logic [4:0]    wr_sel;
	logic          sel_ok;
	logic          ready_next;
	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	dcfm_edge_ctr u_edge (
		.clk    (clk),
		.resetn (resetn),
		.cif    (ctr)
	);
	dcfm_tb_ctr u_tb (
		.clk    (clk),
		.resetn (resetn),
		.cif    (ctr)
	);
	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero wait state: every access completes in its access phase
	assign pready    = 1'b1;
	assign wr_en     = psel & penable & pwrite;
	assign hit_ctrl  = (paddr == `DCFM_OFF_CTRL);
	assign hit_cword = (paddr == `DCFM_OFF_CWORD);
	assign hit_edge  = (paddr == `DCFM_OFF_EDGE);
	assign hit_tbase = (paddr == `DCFM_OFF_TBASE);
	assign hit_stat  = (paddr == `DCFM_OFF_STAT);
	assign mapped    = hit_ctrl | hit_cword | hit_edge | hit_tbase | hit_stat;
	// unmapped or misaligned addresses answer with an error
	assign pslverr   = psel & penable & ~mapped;
	// read mux, reserved bits zero
	assign prdata = hit_ctrl  ? {30'h0, mode_reg} :
		hit_cword ? {22'h0, narrow_reg, pol_reg, 3'h0, sel_reg} :
		hit_edge  ? {16'h0, edge_hold_reg} :
		hit_tbase ? {10'h0, tb_hold_reg} :
		hit_stat  ? {26'h0, state_reg, phase_reg, ctr.run, ready_reg} :
		32'h0;
	// ------------------------------------------------------------
	// control word
	// ------------------------------------------------------------
	// only the 25 defined sources are accepted
	assign wr_sel = pwdata[`DCFM_CW_SEL_HI:0];
	assign sel_ok = (wr_sel <= `DCFM_SRC_MAX);
	// mode and control word registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg   <= DCFM_NATIVE;
			sel_reg    <= `DCFM_SRC_GND;
			pol_reg    <= 1'b0;
			narrow_reg <= 1'b0;
		end else begin
			if (wr_en & hit_ctrl) begin
				mode_reg <= pwdata[1:0];
			end
			// source and conditioning from one word
			if (wr_en & hit_cword & sel_ok) begin
				sel_reg    <= wr_sel;
				pol_reg    <= pwdata[`DCFM_CW_POL];
				narrow_reg <= pwdata[`DCFM_CW_NARROW];
			end
		end
	end
	// zero point is the grounded pair code
	assign mux_sel = sel_reg;
	assign cond_polarity = pol_reg;
	// narrow reference codes force restricted range
	assign cond_narrow = narrow_reg | (sel_reg == `DCFM_SRC_RTL_N) |
		(sel_reg == `DCFM_SRC_RTH_N);
	// ------------------------------------------------------------
	// frame phase and flags
	// ------------------------------------------------------------
	// unused code behaves as native
	assign mode_eff  = dcfm_mode_norm(mode_reg);
	assign cont_mode = (mode_eff == DCFM_CONTINUOUS);
	// major frame restarts the four-frame cycle
	assign phase_next = major_frame ? `DCFM_PHASE_RST : phase_reg + 1'b1;
	// frame strobes arm window start and stop
	// even frames count, odd frames rest
	assign start_flag = minor_frame & ~phase_next[0] & ~cont_mode;
	assign end_flag   = minor_frame & phase_next[0] & ~cont_mode;
	// phase counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= `DCFM_PHASE_RST;
		end else if (minor_frame) begin
			phase_reg <= phase_next;
		end
	end
	// ------------------------------------------------------------
	// converter edges
	// ------------------------------------------------------------
	// taken as is; a two-tick error is about 1 ppm
	assign vfc_rise = vfc_in & ~vfc_reg;
	assign vfc_edge = vfc_in ^ vfc_reg;
	// previous converter level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vfc_reg <= 1'b0;
		end else begin
			vfc_reg <= vfc_in;
		end
	end
	// ------------------------------------------------------------
	// window sequencer
	// ------------------------------------------------------------
	// flags only arm; rising edges act
	assign arm_hit  = (state_reg == DCFM_ARM) & vfc_rise;
	assign stop_hit = (state_reg == DCFM_DRAIN) & vfc_rise;
	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			DCFM_IDLE: begin
				if (start_flag) begin
					state_next = DCFM_ARM;
				end
			end
			DCFM_ARM: begin
				// dead converter: frame ends with no edge, drop window
				if (end_flag) begin
					state_next = DCFM_IDLE;
				end else if (vfc_rise) begin
					state_next = DCFM_RUN;
				end
			end
			DCFM_RUN: begin
				if (end_flag) begin
					state_next = DCFM_DRAIN;
				end
			end
			DCFM_DRAIN: begin
				if (vfc_rise) begin
					state_next = DCFM_IDLE;
				end
			end
			default: begin
				state_next = DCFM_IDLE;
			end
		endcase
		// continuous mode bypasses framing entirely
		if (cont_mode) begin
			state_next = DCFM_IDLE;
		end
	end
	// state and window identity
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg  <= DCFM_IDLE;
			win_id_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (start_flag & (state_reg == DCFM_IDLE)) begin
				win_id_reg <= phase_next[1];
			end
		end
	end
	// ------------------------------------------------------------
	// counter gating
	// ------------------------------------------------------------
	// clear on the aligned start edge
	assign ctr.clr = arm_hit & ~cont_mode;
	// continuous mode keeps both counters running
	assign ctr.run = cont_mode | (state_reg == DCFM_RUN) | (state_reg == DCFM_DRAIN);
	// inhibit mode stops the timebase counter
	assign ctr.tb_en    = (mode_eff != DCFM_TB_INHIBIT);
	assign ctr.edge_evt = vfc_edge;
	// ------------------------------------------------------------
	// result holding
	// ------------------------------------------------------------
	// only the second window of four frames is kept
	assign latch_native = stop_hit & win_id_reg;
	// free-running counts captured at major frame
	assign latch_cont = cont_mode & major_frame;
	// stop edge is counted in the same cycle, so hold next value
	assign latch = latch_native | latch_cont;
	// set wins over a same-cycle clear
	assign ready_next = latch | (ready_reg & ~(wr_en & hit_stat & pwdata[`DCFM_ST_READY]));
	// holding registers and result flags
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			edge_hold_reg <= '0;
			tb_hold_reg   <= '0;
			ready_reg     <= 1'b0;
			strobe_reg    <= 1'b0;
		end else begin
			if (latch_native) begin
				edge_hold_reg <= ctr.edge_count + EW'(vfc_edge);
				tb_hold_reg   <= ctr.tb_count;
			end else if (latch_cont) begin
				edge_hold_reg <= ctr.edge_count;
				tb_hold_reg   <= ctr.tb_count;
			end
			ready_reg  <= ready_next;
			strobe_reg <= latch;
		end
	end
	assign result_strobe = strobe_reg;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_arm_rise;
		(state_reg == DCFM_ARM) && vfc_rise && !end_flag && !cont_mode;
	endsequence
	sequence s_drain_rise;
		(state_reg == DCFM_DRAIN) && vfc_rise && !cont_mode;
	endsequence
	a_start_aligned: assert property (
		s_arm_rise |=> (state_reg == DCFM_RUN) && ctr.run && ctr.edge_count == '0)
		else $error("window did not open on converter rise");
	a_stop_aligned: assert property (
		s_drain_rise |=> (state_reg == DCFM_IDLE) && !ctr.run)
		else $error("window did not close on converter rise");
	a_arm_waits: assert property (
		(state_reg == DCFM_ARM) && !vfc_rise && !end_flag && !cont_mode
		|=> (state_reg == DCFM_ARM) && !ctr.run)
		else $error("counting began without a rising edge");
	a_odd_no_arm: assert property (
		minor_frame && phase_next[0] && (state_reg == DCFM_IDLE) |=> state_reg == DCFM_IDLE)
		else $error("window opened in a rest frame");
	a_native_hold: assert property (
		s_drain_rise ##0 win_id_reg |=> tb_hold_reg == $past(ctr.tb_count) && result_strobe)
		else $error("fourth-frame result not held");
	a_cont_latch: assert property (
		cont_mode && major_frame |=> edge_hold_reg == $past(ctr.edge_count) && ready_reg)
		else $error("continuous capture missed major frame");
	a_cont_runs: assert property (
		cont_mode |-> ctr.run && !ctr.clr)
		else $error("continuous mode stopped counting");
	a_default_native: assert property (
		mode_reg == 2'h3 |-> ctr.tb_en && (ctr.run == (state_reg[0] | state_reg[1]) ||
		state_reg == DCFM_ARM))
		else $error("spare mode code not native");
	a_sel_range: assert property (
		mux_sel <= `DCFM_SRC_MAX)
		else $error("source select beyond defined sources");
	a_narrow_ref: assert property (
		mux_sel == `DCFM_SRC_RTL_N |-> cond_narrow)
		else $error("narrow reference not in restricted range");
endmodule : dcfm_top
`default_nettype wire
